//--- pkg/fss_regs.vh
`ifndef FSS_REGS_VH
`define FSS_REGS_VH

// Opcodes
`define FSS_OP_WREN        8'h06
`define FSS_OP_RDSR        8'h05
`define FSS_OP_SEC_ERASE   8'h44
`define FSS_OP_SEC_PROG    8'h42
`define FSS_OP_SEC_READ    8'h48
`define FSS_OP_SET_PARAM   8'hc0
`define FSS_OP_FAST_READ   8'h0b
`define FSS_OP_QIO_READ    8'heb
`define FSS_OP_WRAP_READ   8'h0c
`define FSS_OP_SET_WRAP    8'h77
`define FSS_OP_QPI_ON      8'h38
`define FSS_OP_QPI_OFF     8'hff
`define FSS_OP_RST_EN      8'h66
`define FSS_OP_RST         8'h99

// Security sector geometry
`define FSS_SEC_AW         10
`define FSS_SEC_BYTES      1024

// Frame positions, in bytes including the opcode
`define FSS_ADDR_LAST      3'h4
`define FSS_PROG_MIN       3'h5
`define FSS_WRAP_BYTE      3'h4
`define FSS_PARAM_BYTE     3'h1
`define FSS_BYTE_BITS      4'h8

// Read parameter fields
`define FSS_DUMMY_MSB      5
`define FSS_DUMMY_LSB      4
`define FSS_WRAP_MSB       1
`define FSS_WRAP_LSB       0
`define FSS_BWRAP_MSB      5
`define FSS_BWRAP_LSB      4
`define FSS_SPI_DUMMY      4'h8
`define FSS_PARAM_RST      2'h0

// Status byte bit positions
`define FSS_ST_WIP         0
`define FSS_ST_WEL         1

// Output enables per mode
`define FSS_OE_SPI         4'h2
`define FSS_OE_QPI         4'hf

// Timing
`define FSS_CLK_MHZ        100
`define FSS_RST_TIME_US    30

`endif

//--- verilog/fss_top.v
`timescale 1ns/1ns
// Contract
// - One 1024-byte security sector, separate array, 10-bit byte offset.
// - Erase is 44h plus 24-bit address, accepted only with write enable latch set.
// - Erase runs only if chip select rises right after final address byte.
// - Erase holds busy flag, status still readable, then clears busy and latch.
// - Lock bit set makes security erase and program ignored while the lock input stays set.
// - Program is 42h, address, 1 to 256 bytes, needs latch set.
// - Read is 48h, address, eight dummy clocks, data until chip select rises.
// - Sample on rising clock edges, shift out on falling, MSB first.
// - Read address increments per byte, 3FFh wraps to 00h.
// - Security read during busy cycle is ignored, cycle undisturbed.
// - C0h accepted only in four-lane mode, rejected in serial mode.
// - Dummy field codes give 2, 4, 6, 8 clocks for four-lane reads.
// - Wrap field codes give wrap length 8, 16, 32, 64 bytes.
// - Power-up or reset defaults: wrap eight bytes, two dummy clocks.
// - Serial mode takes wrap from 77h burst-wrap field, kept across mode switch.
// - 0Ch acts as fast read but wraps inside aligned wrap window.
// - 38h enters four-lane mode only when quad enable bit is set.
// - Start in serial mode, never four-lane; modes never run together.
// - FFh leaves four-lane mode; latch and wrap setting preserved both ways.
// - Reset needs 66h then 99h; any other command disarms.
// - Reset aborts work, restores defaults, refuses commands about 30 us.
`include "fss_regs.vh"

module fss_fifo #(
  parameter WIDTH = 18,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             rst_b_i,
  input  wire             clear_i,
  // Fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] buf_ff [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      cnt_ff;
  wire            push;
  wire            pop;

  function [AW-1:0] fss_ptr_inc;
    input [AW-1:0] p;
    begin
      fss_ptr_inc = (p == DEPTH - 1) ? {AW{1'b0}} : p + 1'b1;
    end
  endfunction

  assign in_ready_o  = (cnt_ff != DEPTH);
  assign out_valid_o = (cnt_ff != {(AW+1){1'b0}});
  assign out_data_o  = buf_ff[rd_ptr_ff];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge clk_i) begin
    if (push) begin
      buf_ff[wr_ptr_ff] <= in_data_i;
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      cnt_ff    <= {(AW+1){1'b0}};
    end else if (clear_i) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      cnt_ff    <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= fss_ptr_inc(wr_ptr_ff);
      end
      if (pop) begin
        rd_ptr_ff <= fss_ptr_inc(rd_ptr_ff);
      end
      if (push & ~pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop & ~push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule

module fss_top #(
  parameter [19:0] ERASE_CYCLES = 20'd300000,
  parameter [19:0] PROG_CYCLES  = 20'd5000,
  parameter        FIFO_DEPTH   = 8
) (
  // Clock and reset
  input  wire       clk_i,
  input  wire       rst_b_i,
  // Serial link pins
  input  wire       sclk_i,
  input  wire       cs_b_i,
  input  wire [3:0] sio_i,
  output reg  [3:0] sio_o,
  output reg  [3:0] sio_oe_o,
  // Status bits held outside this block
  input  wire       security_lock_bit_i,
  input  wire       quad_enable_bit_i,
  // Visible state
  output reg        write_in_progress_flag_o,
  output reg        write_enable_latch_bit_o,
  output reg        four_lane_command_mode_o,
  output reg  [1:0] dummy_count_field_o,
  output reg  [1:0] wrap_length_field_o,
  output reg        reset_busy_o
);
  localparam PH_OPC   = 3'h0;
  localparam PH_ADDR  = 3'h1;
  localparam PH_DUMMY = 3'h2;
  localparam PH_WDATA = 3'h3;
  localparam PH_OUT   = 3'h4;
  localparam PH_PARAM = 3'h5;
  localparam PH_IGN   = 3'h6;
  localparam AW       = `FSS_SEC_AW;
  localparam integer RST_CYC_I = `FSS_RST_TIME_US * `FSS_CLK_MHZ;
  localparam [19:0] RST_CYC = RST_CYC_I[19:0];

  // Sync chains: sclk, cs, four data lanes
  reg  [5:0]    s1_ff;
  reg  [5:0]    s2_ff;
  reg  [5:0]    s3_ff;
  reg  [5:0]    filt_ff;
  reg  [5:0]    prev_ff;
  wire [5:0]    nxt_filt;
  wire          sclk_rise;
  wire          sclk_fall;
  wire          cs_rise;
  wire          cs_low;
  wire [3:0]    lane_in;

  reg  [2:0]    phase_ff;
  reg  [7:0]    opc_ff;
  reg  [7:0]    sh_ff;
  reg  [3:0]    bit_cnt_ff;
  reg  [2:0]    byte_cnt_ff;
  reg  [23:0]   addr_ff;
  reg  [3:0]    dum_cnt_ff;
  reg  [3:0]    dum_need_ff;
  reg  [7:0]    out_sr_ff;
  reg  [3:0]    out_cnt_ff;
  reg           src_status_ff;
  reg           cmd_ok_ff;
  reg           prog_bad_ff;
  reg           armed_ff;
  reg  [19:0]   busy_cnt_ff;
  reg           erase_run_ff;
  reg  [AW-1:0] erase_idx_ff;
  reg  [7:0]    mem_ff [0:`FSS_SEC_BYTES-1];

  wire [7:0]    nxt_sh;
  wire [3:0]    nxt_bit_cnt;
  wire          byte_done;
  wire [7:0]    status_byte;
  wire [7:0]    fresh_byte;
  wire [7:0]    cur_byte;
  wire          push_valid;
  wire          push_ready;
  wire          drain_valid;
  wire          drain_ready;
  wire [AW+7:0] drain_data;
  wire          do_reset;

  function [3:0] fss_dummy_clocks;
    input [1:0] f;
    begin
      fss_dummy_clocks = {1'b0, f, 1'b0} + 4'h2;
    end
  endfunction

  function [AW-1:0] fss_next_addr;
    input [AW-1:0] a;
    input [1:0]    wrap;
    input          wrap_en;
    reg   [AW-1:0] mask;
    begin
      mask = ({{(AW-4){1'b0}}, 4'h8} << wrap) - 1'b1;
      if (wrap_en) begin
        fss_next_addr = (a & ~mask) | ((a + 1'b1) & mask);
      end else begin
        fss_next_addr = a + 1'b1;
      end
    end
  endfunction

  // A change counts only once the second and third stages agree
  assign nxt_filt  = (s3_ff & ~(s2_ff ^ s3_ff)) | (filt_ff & (s2_ff ^ s3_ff));
  assign sclk_rise = filt_ff[0] & ~prev_ff[0];
  assign sclk_fall = ~filt_ff[0] & prev_ff[0];
  assign cs_rise   = filt_ff[1] & ~prev_ff[1];
  assign cs_low    = ~filt_ff[1];
  assign lane_in   = filt_ff[5:2];

  assign nxt_sh      = four_lane_command_mode_o ? {sh_ff[3:0], lane_in} : {sh_ff[6:0], lane_in[0]};
  assign nxt_bit_cnt = bit_cnt_ff + (four_lane_command_mode_o ? 4'h4 : 4'h1);
  assign byte_done   = sclk_rise & cs_low & (nxt_bit_cnt == `FSS_BYTE_BITS);
  assign do_reset    = byte_done & (phase_ff == PH_OPC) & ~reset_busy_o & armed_ff
                       & (nxt_sh == `FSS_OP_RST);

  assign status_byte = {6'h00, write_enable_latch_bit_o, write_in_progress_flag_o};
  assign fresh_byte  = src_status_ff ? status_byte : mem_ff[addr_ff[AW-1:0]];
  assign cur_byte    = (out_cnt_ff == 4'h0) ? fresh_byte : out_sr_ff;

  assign push_valid  = byte_done & (phase_ff == PH_WDATA);
  // Array has one write port; erase owns it while it runs
  assign drain_ready = ~erase_run_ff;

  fss_fifo #(
    .WIDTH (AW + 8),
    .DEPTH (FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .clear_i     (do_reset),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   ({addr_ff[AW-1:0], nxt_sh}),
    .out_valid_o (drain_valid),
    .out_ready_i (drain_ready),
    .out_data_o  (drain_data)
  );

  // Flash programming can only clear bits
  always @(posedge clk_i) begin
    if (erase_run_ff) begin
      mem_ff[erase_idx_ff] <= 8'hff;
    end else if (drain_valid) begin
      mem_ff[drain_data[AW+7:8]] <= mem_ff[drain_data[AW+7:8]] & drain_data[7:0];
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_ff   <= 6'h02;
      s2_ff   <= 6'h02;
      s3_ff   <= 6'h02;
      filt_ff <= 6'h02;
      prev_ff <= 6'h02;
    end else begin
      s1_ff   <= {sio_i, cs_b_i, sclk_i};
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      filt_ff <= nxt_filt;
      prev_ff <= filt_ff;
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_ff                 <= PH_OPC;
      opc_ff                   <= 8'h00;
      sh_ff                    <= 8'h00;
      bit_cnt_ff               <= 4'h0;
      byte_cnt_ff              <= 3'h0;
      addr_ff                  <= 24'h000000;
      dum_cnt_ff               <= 4'h0;
      dum_need_ff              <= 4'h0;
      out_sr_ff                <= 8'h00;
      out_cnt_ff               <= 4'h0;
      src_status_ff            <= 1'b0;
      cmd_ok_ff                <= 1'b0;
      prog_bad_ff              <= 1'b0;
      armed_ff                 <= 1'b0;
      busy_cnt_ff              <= 20'h00000;
      erase_run_ff             <= 1'b0;
      erase_idx_ff             <= {AW{1'b0}};
      sio_o                    <= 4'h0;
      sio_oe_o                 <= 4'h0;
      write_in_progress_flag_o <= 1'b0;
      write_enable_latch_bit_o <= 1'b0;
      four_lane_command_mode_o <= 1'b0;
      dummy_count_field_o      <= `FSS_PARAM_RST;
      wrap_length_field_o      <= `FSS_PARAM_RST;
      reset_busy_o             <= 1'b0;
    end else begin
      // Self-timed cycles
      if (erase_run_ff) begin
        erase_idx_ff <= erase_idx_ff + 1'b1;
        if (erase_idx_ff == {AW{1'b1}}) begin
          erase_run_ff <= 1'b0;
        end
      end
      if (busy_cnt_ff != 20'h00000) begin
        busy_cnt_ff <= busy_cnt_ff - 1'b1;
        if (busy_cnt_ff == 20'h00001) begin
          if (write_in_progress_flag_o) begin
            write_in_progress_flag_o <= 1'b0;
            write_enable_latch_bit_o <= 1'b0;
          end
          reset_busy_o <= 1'b0;
        end
      end

      if (cs_rise) begin
        // Erase only when the frame ends exactly after the last address byte
        if (cmd_ok_ff && opc_ff == `FSS_OP_SEC_ERASE && byte_cnt_ff == `FSS_ADDR_LAST
            && bit_cnt_ff == 4'h0) begin
          write_in_progress_flag_o <= 1'b1;
          busy_cnt_ff              <= ERASE_CYCLES;
          erase_run_ff             <= 1'b1;
          erase_idx_ff             <= {AW{1'b0}};
        end
        if (cmd_ok_ff && opc_ff == `FSS_OP_SEC_PROG && byte_cnt_ff >= `FSS_PROG_MIN
            && bit_cnt_ff == 4'h0 && !prog_bad_ff) begin
          write_in_progress_flag_o <= 1'b1;
          busy_cnt_ff              <= PROG_CYCLES;
        end
        phase_ff    <= PH_OPC;
        bit_cnt_ff  <= 4'h0;
        byte_cnt_ff <= 3'h0;
        out_cnt_ff  <= 4'h0;
        cmd_ok_ff   <= 1'b0;
        prog_bad_ff <= 1'b0;
        sio_oe_o    <= 4'h0;
      end else if (sclk_rise && cs_low) begin
        sh_ff      <= nxt_sh;
        bit_cnt_ff <= byte_done ? 4'h0 : nxt_bit_cnt;
        if (byte_done && byte_cnt_ff != 3'h7) begin
          byte_cnt_ff <= byte_cnt_ff + 1'b1;
        end
        if (byte_done) begin
          case (phase_ff)
            PH_OPC: begin
              opc_ff   <= nxt_sh;
              phase_ff <= PH_IGN;
              armed_ff <= (nxt_sh == `FSS_OP_RST_EN) & ~reset_busy_o;
              if (reset_busy_o) begin
                phase_ff <= PH_IGN;
              end else if (do_reset) begin
                // Abort everything and restore power-on defaults
                write_in_progress_flag_o <= 1'b0;
                write_enable_latch_bit_o <= 1'b0;
                four_lane_command_mode_o <= 1'b0;
                dummy_count_field_o      <= `FSS_PARAM_RST;
                wrap_length_field_o      <= `FSS_PARAM_RST;
                erase_run_ff             <= 1'b0;
                busy_cnt_ff              <= RST_CYC;
                reset_busy_o             <= 1'b1;
              end else if (nxt_sh == `FSS_OP_RDSR) begin
                src_status_ff <= 1'b1;
                phase_ff      <= PH_OUT;
              end else if (write_in_progress_flag_o) begin
                phase_ff <= PH_IGN;
              end else begin
                src_status_ff <= 1'b0;
                case (nxt_sh)
                  `FSS_OP_WREN: begin
                    write_enable_latch_bit_o <= 1'b1;
                  end
                  `FSS_OP_SEC_ERASE, `FSS_OP_SEC_PROG: begin
                    if (!four_lane_command_mode_o && write_enable_latch_bit_o
                        && !security_lock_bit_i) begin
                      cmd_ok_ff <= 1'b1;
                      phase_ff  <= PH_ADDR;
                    end
                  end
                  `FSS_OP_SEC_READ: begin
                    if (!four_lane_command_mode_o) begin
                      dum_need_ff <= `FSS_SPI_DUMMY;
                      phase_ff    <= PH_ADDR;
                    end
                  end
                  `FSS_OP_FAST_READ, `FSS_OP_QIO_READ, `FSS_OP_WRAP_READ: begin
                    if (four_lane_command_mode_o) begin
                      dum_need_ff <= fss_dummy_clocks(dummy_count_field_o);
                      phase_ff    <= PH_ADDR;
                    end
                  end
                  `FSS_OP_SET_PARAM: begin
                    if (four_lane_command_mode_o) begin
                      phase_ff <= PH_PARAM;
                    end
                  end
                  `FSS_OP_SET_WRAP: begin
                    if (!four_lane_command_mode_o) begin
                      phase_ff <= PH_PARAM;
                    end
                  end
                  `FSS_OP_QPI_ON: begin
                    if (quad_enable_bit_i) begin
                      four_lane_command_mode_o <= 1'b1;
                    end
                  end
                  `FSS_OP_QPI_OFF: begin
                    four_lane_command_mode_o <= 1'b0;
                  end
                  default: begin
                    phase_ff <= PH_IGN;
                  end
                endcase
              end
            end
            PH_ADDR: begin
              addr_ff <= {addr_ff[15:0], nxt_sh};
              if (byte_cnt_ff == `FSS_ADDR_LAST - 1'b1) begin
                if (opc_ff == `FSS_OP_SEC_PROG) begin
                  phase_ff <= PH_WDATA;
                end else if (opc_ff == `FSS_OP_SEC_ERASE) begin
                  phase_ff <= PH_IGN;
                end else begin
                  dum_cnt_ff <= 4'h0;
                  phase_ff   <= PH_DUMMY;
                end
              end
            end
            PH_WDATA: begin
              // Address wraps inside the 256-byte page
              addr_ff[7:0] <= addr_ff[7:0] + 1'b1;
              if (!push_ready) begin
                prog_bad_ff <= 1'b1;
              end
            end
            PH_PARAM: begin
              if (opc_ff == `FSS_OP_SET_PARAM && byte_cnt_ff == `FSS_PARAM_BYTE) begin
                dummy_count_field_o <= nxt_sh[`FSS_DUMMY_MSB:`FSS_DUMMY_LSB];
                wrap_length_field_o <= nxt_sh[`FSS_WRAP_MSB:`FSS_WRAP_LSB];
              end
              if (opc_ff == `FSS_OP_SET_WRAP && byte_cnt_ff == `FSS_WRAP_BYTE) begin
                wrap_length_field_o <= nxt_sh[`FSS_BWRAP_MSB:`FSS_BWRAP_LSB];
              end
            end
            default: begin
              phase_ff <= phase_ff;
            end
          endcase
        end
        // After the byte decode: the last dummy edge often also ends a byte
        if (phase_ff == PH_DUMMY) begin
          dum_cnt_ff <= dum_cnt_ff + 1'b1;
          if (dum_cnt_ff + 1'b1 == dum_need_ff) begin
            phase_ff <= PH_OUT;
          end
        end
      end else if (sclk_fall && cs_low && phase_ff == PH_OUT) begin
        // Shift out MSB first on the falling edge
        if (four_lane_command_mode_o) begin
          sio_o     <= cur_byte[7:4];
          sio_oe_o  <= `FSS_OE_QPI;
          out_sr_ff <= {cur_byte[3:0], 4'h0};
        end else begin
          sio_o     <= {2'b00, cur_byte[7], 1'b0};
          sio_oe_o  <= `FSS_OE_SPI;
          out_sr_ff <= {cur_byte[6:0], 1'b0};
        end
        if (out_cnt_ff + (four_lane_command_mode_o ? 4'h4 : 4'h1) == `FSS_BYTE_BITS) begin
          out_cnt_ff <= 4'h0;
          if (!src_status_ff) begin
            addr_ff[AW-1:0] <= fss_next_addr(addr_ff[AW-1:0], wrap_length_field_o,
                                             opc_ff == `FSS_OP_WRAP_READ);
          end
        end else begin
          out_cnt_ff <= out_cnt_ff + (four_lane_command_mode_o ? 4'h4 : 4'h1);
        end
      end
    end
  end
endmodule

//--- dv/fss_properties.sv
`timescale 1ns/1ns
`include "fss_regs.vh"
module fss_properties #(
  parameter [19:0] ERASE_CYCLES = 20'd300000,
  parameter [19:0] PROG_CYCLES  = 20'd5000
) (
  input wire       clk_i,
  input wire       rst_b_i,
  input wire       cs_b_i,
  input wire [3:0] sio_oe_o,
  input wire       security_lock_bit_i,
  input wire       quad_enable_bit_i,
  input wire       write_in_progress_flag_o,
  input wire       write_enable_latch_bit_o,
  input wire       four_lane_command_mode_o,
  input wire [1:0] dummy_count_field_o,
  input wire [1:0] wrap_length_field_o,
  input wire       reset_busy_o
);
  localparam int RST_CYC = `FSS_RST_TIME_US * `FSS_CLK_MHZ;
  reg [19:0] bcnt_ff;
  reg [19:0] rcnt_ff;
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bcnt_ff <= 20'h0;
      rcnt_ff <= 20'h0;
    end else begin
      bcnt_ff <= write_in_progress_flag_o ? bcnt_ff + 20'h1 : 20'h0;
      rcnt_ff <= reset_busy_o ? rcnt_ff + 20'h1 : 20'h0;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  mode_lanes_a: assert property (sio_oe_o == 4'h0 || sio_oe_o ==
    (four_lane_command_mode_o ? `FSS_OE_QPI : `FSS_OE_SPI)) else $error("lane enables wrong");
  idle_quiet_a: assert property (cs_b_i [*8] |-> sio_oe_o == 4'h0)
    else $error("lanes driven while deselected");
  busy_len_a: assert property ($fell(write_in_progress_flag_o) && !reset_busy_o |->
    bcnt_ff == ERASE_CYCLES || bcnt_ff == PROG_CYCLES) else $error("busy length wrong");
  done_clears_a: assert property ($fell(write_in_progress_flag_o) |->
    !write_enable_latch_bit_o) else $error("latch kept after busy");
  lock_blocks_a: assert property ($rose(write_in_progress_flag_o) |->
    !security_lock_bit_i) else $error("busy started while locked");
  qpi_gate_a: assert property ($rose(four_lane_command_mode_o) |->
    quad_enable_bit_i) else $error("four-lane mode without quad enable");
  mode_keep_a: assert property ($changed(four_lane_command_mode_o) |-> reset_busy_o ||
    $stable(write_enable_latch_bit_o) && $stable(wrap_length_field_o))
    else $error("mode switch changed latch or wrap");
  param_qpi_a: assert property ($changed(dummy_count_field_o) |->
    four_lane_command_mode_o || reset_busy_o) else $error("dummy code set in serial mode");
  rst_len_a: assert property ($fell(reset_busy_o) |-> rcnt_ff == RST_CYC)
    else $error("reset busy length wrong");
  rst_quiet_a: assert property (reset_busy_o [*2] |-> !write_enable_latch_bit_o &&
    !four_lane_command_mode_o && dummy_count_field_o == 2'h0 && wrap_length_field_o == 2'h0)
    else $error("state not default during reset");
  cover property ($fell(write_in_progress_flag_o));
  cover property ($rose(four_lane_command_mode_o));
  cover property ($fell(reset_busy_o));
endmodule
bind fss_top fss_properties #(.ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES)) u_chk (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b_i), .sio_oe_o(sio_oe_o),
  .security_lock_bit_i(security_lock_bit_i), .quad_enable_bit_i(quad_enable_bit_i),
  .write_in_progress_flag_o(write_in_progress_flag_o),
  .write_enable_latch_bit_o(write_enable_latch_bit_o),
  .four_lane_command_mode_o(four_lane_command_mode_o),
  .dummy_count_field_o(dummy_count_field_o), .wrap_length_field_o(wrap_length_field_o),
  .reset_busy_o(reset_busy_o));

//--- dv/fss_host_model.sv
`timescale 1ns/1ns
module fss_host_model (
  // Clock
  input  wire       clk_i,
  // Link
  output reg        sclk_o,
  output reg        cs_b_o,
  output reg  [3:0] sio_o,
  input  wire [3:0] sio_i,
  input  wire       qpi_i
);
  initial begin
    sclk_o = 1'b0;
    cs_b_o = 1'b1;
    sio_o = 4'h0;
  end
  // Eight system clocks per half period gives the 160 ns link clock
  task automatic half;
    repeat (8) @(negedge clk_i);
  endtask
  task automatic tick(input [3:0] d, output [3:0] q);
    begin
      sio_o = d;
      half;
      sclk_o = 1'b1;
      q = sio_i;
      half;
      sclk_o = 1'b0;
    end
  endtask
  task automatic xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    reg [3:0] q;
    begin
      for (i = 0; i < (qpi_i ? 2 : 8); i = i + 1) begin
        tick(qpi_i ? tx[7:4] : {3'h0, tx[7]}, q);
        rx = qpi_i ? {rx[3:0], q} : {rx[6:0], q[1]};
        tx = qpi_i ? {tx[3:0], 4'h0} : {tx[6:0], 1'b0};
      end
    end
  endtask
  task automatic open_frame;
    begin
      cs_b_o = 1'b0;
      half;
    end
  endtask
  // Released lanes show the inverse so a stale value is never read as data
  task automatic close_frame;
    begin
      half;
      cs_b_o = 1'b1;
      sio_o = ~sio_o;
      repeat (12) @(negedge clk_i);
    end
  endtask
endmodule

//--- dv/fss_tb_top.sv
`timescale 1ns/1ns
`include "fss_regs.vh"
module fss_tb_top;
  reg clk_i, rst_b_i, lock, qe, m_qpi;
  wire sclk, cs_b, write_in_progress_flag, write_enable_latch_bit, four_lane_command_mode, rb;
  wire [3:0] hsio, dsio, doe;
  wire [1:0] dum, wrp;
  wire [3:0] lanes = (doe & dsio) | (~doe & hsio);
  integer n_mismatch, cmp_count, seed, rnd, i, k, a, m_wip, m_wel, m_dum, m_wrap, m_rb;
  integer m_sec [0:1023];
  reg [7:0] rdq [$];
  always #5 clk_i = ~clk_i;
  fss_top #(.ERASE_CYCLES(20'd2000), .PROG_CYCLES(20'd50)) u_fss_top (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .sclk_i(sclk), .cs_b_i(cs_b), .sio_i(lanes),
    .sio_o(dsio), .sio_oe_o(doe), .security_lock_bit_i(lock), .quad_enable_bit_i(qe),
    .write_in_progress_flag_o(write_in_progress_flag), .write_enable_latch_bit_o(write_enable_latch_bit),
    .four_lane_command_mode_o(four_lane_command_mode), .dummy_count_field_o(dum),
    .wrap_length_field_o(wrp), .reset_busy_o(rb));
  fss_host_model u_fss_host_model (.clk_i(clk_i), .sclk_o(sclk), .cs_b_o(cs_b),
    .sio_o(hsio), .sio_i(lanes), .qpi_i(m_qpi));
  task automatic end_of_test;
    begin
      if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task automatic check(input [63:0] seen, input [63:0] exp, input [8*10-1:0] what);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED %0s expected %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  task automatic st;
    check({write_in_progress_flag, write_enable_latch_bit, four_lane_command_mode, dum, wrp, rb},
      {m_wip[0], m_wel[0], m_qpi, m_dum[1:0], m_wrap[1:0], m_rb[0]}, "state");
  endtask
  task automatic frame(input [63:0] w, input integer n, input integer dc, input integer nrd);
    integer j;
    reg [7:0] r;
    reg [3:0] q;
    begin
      rdq = {};
      u_fss_host_model.open_frame;
      for (j = 0; j < n; j = j + 1) u_fss_host_model.xfer(w[63-8*j -: 8], r);
      for (j = 0; j < dc; j = j + 1) u_fss_host_model.tick(4'h0, q);
      for (j = 0; j < nrd; j = j + 1) begin
        u_fss_host_model.xfer(8'h00, r);
        rdq.push_back(r);
      end
      u_fss_host_model.close_frame;
    end
  endtask
  task automatic op(input [7:0] c);
    frame({c, 56'h0}, 1, 0, 0);
  endtask
  task automatic wait_idle(input integer lim);
    integer j;
    begin
      for (j = 0; j < lim && (write_in_progress_flag !== 1'b0 || rb !== 1'b0); j = j + 1) @(negedge clk_i);
      if (j == lim) begin
        n_mismatch = n_mismatch + 1;
        end_of_test;
      end
    end
  endtask
  initial begin
    clk_i = 1'b0; rst_b_i = 1'b0; lock = 1'b0; qe = 1'b0; m_qpi = 1'b0;
    n_mismatch = 0; cmp_count = 0; seed = 93;
    m_wip = 0; m_wel = 0; m_dum = 0; m_wrap = 0; m_rb = 0;
    repeat (10) @(negedge clk_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge clk_i);
    st;
    frame({`FSS_OP_SEC_ERASE, 56'h0}, 4, 0, 0);
    st;
    op(`FSS_OP_WREN);
    m_wel = 1;
    frame({`FSS_OP_SEC_ERASE, 56'h0}, 5, 0, 0);
    st;
    frame({`FSS_OP_SEC_ERASE, 56'h0}, 4, 0, 0);
    m_wip = 1;
    st;
    frame({`FSS_OP_SEC_READ, 56'h0}, 4, 8, 1);
    frame({`FSS_OP_RDSR, 56'h0}, 1, 0, 1);
    check(rdq[0], 8'h03, "status");
    wait_idle(3000);
    m_wip = 0;
    m_wel = 0;
    for (i = 0; i < 1024; i = i + 1) m_sec[i] = 255;
    st;
    rnd = $random(seed);
    op(`FSS_OP_WREN);
    frame({`FSS_OP_SEC_PROG, 24'h0003ff, rnd[15:0], 16'h0}, 6, 0, 0);
    m_sec[1023] = rnd[15:8];
    m_sec[768] = rnd[7:0];
    wait_idle(200);
    frame({`FSS_OP_SEC_READ, 24'h0003ff, 32'h0}, 4, 8, 2);
    check(rdq[0], m_sec[1023], "sec data");
    check(rdq[1], m_sec[0], "sec data");
    lock = 1'b1;
    op(`FSS_OP_WREN);
    m_wel = 1;
    frame({`FSS_OP_SEC_PROG, 24'h0, 8'h00, 24'h0}, 5, 0, 0);
    frame({`FSS_OP_SEC_ERASE, 56'h0}, 4, 0, 0);
    st;
    lock = 1'b0;
    frame({`FSS_OP_SET_WRAP, 24'h0, 8'h20, 24'h0}, 5, 0, 0);
    m_wrap = 2;
    frame({`FSS_OP_SET_PARAM, 8'h31, 48'h0}, 2, 0, 0);
    op(`FSS_OP_QPI_ON);
    st;
    qe = 1'b1;
    op(`FSS_OP_QPI_ON);
    m_qpi = 1'b1;
    st;
    for (i = 0; i < 4; i = i + 1) begin
      m_dum = i;
      m_wrap = 3 - i;
      frame({`FSS_OP_SET_PARAM, 2'h0, m_dum[1:0], 2'h0, m_wrap[1:0], 48'h0}, 2, 0, 0);
      st;
      frame({`FSS_OP_WRAP_READ, 24'h00033e, 32'h0}, 4, 2 * i + 2, 3);
      a = 830;
      for (k = 0; k < 3; k = k + 1) begin
        check(rdq[k], m_sec[a], "wrap data");
        a = (a & ~((8 << m_wrap) - 1)) | ((a + 1) & ((8 << m_wrap) - 1));
      end
    end
    frame({`FSS_OP_FAST_READ, 24'h0003ff, 32'h0}, 4, 8, 2);
    check(rdq[0], m_sec[1023], "fast data");
    check(rdq[1], m_sec[0], "fast data");
    op(`FSS_OP_QPI_OFF);
    m_qpi = 1'b0;
    st;
    op(`FSS_OP_RST_EN);
    op(`FSS_OP_WREN);
    op(`FSS_OP_RST);
    st;
    frame({`FSS_OP_RDSR, 56'h0}, 1, 0, 1);
    check(rdq[0], 8'h02, "status");
    op(`FSS_OP_RST_EN);
    op(`FSS_OP_RST);
    m_wel = 0; m_dum = 0; m_wrap = 0; m_rb = 1;
    st;
    op(`FSS_OP_WREN);
    st;
    wait_idle(4000);
    m_rb = 0;
    st;
    end_of_test;
  end
endmodule
